// *** core/fppc_pkg.sv ***
// Package for the front panel power control block
package fppc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ            = 20_000_000;
	localparam int unsigned DEBOUNCE_US       = 10_000;
	localparam int unsigned DEBOUNCE_CYCLES   = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
	localparam int unsigned FORCE_OFF_MS      = 4_500;
	localparam int unsigned FORCE_OFF_CYCLES  = (CLK_HZ / 1_000) * FORCE_OFF_MS;
	localparam int unsigned BLINK_HZ          = 1;
	localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
	localparam int unsigned PGOOD_US          = 100_000;
	localparam int unsigned PGOOD_CYCLES      = (CLK_HZ / 1_000_000) * PGOOD_US;
	localparam int unsigned RESET_US          = 1_000;
	localparam int unsigned RESET_CYCLES      = (CLK_HZ / 1_000_000) * RESET_US;
	localparam int unsigned REQ_US            = 100;
	localparam int unsigned REQ_CYCLES        = (CLK_HZ / 1_000_000) * REQ_US;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic IDENTIFY_RESET = 1'b0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FPPC_OFF     = 2'b00,
		FPPC_SUPPLY  = 2'b01,
		FPPC_RESET   = 2'b11,
		FPPC_ON      = 2'b10
	} fppc_state_type;

	// Chipset power-state outputs
	typedef struct packed {
		logic sleep_s1;
		logic off_s5;
	} fppc_chipset_state_type;

	// Requests forwarded to the chipset
	typedef struct packed {
		logic power_button;
		logic reset_button;
	} fppc_chipset_req_type;

endpackage : fppc_pkg

// *** core/fppc_core.sv ***
// Front panel power control: buttons, power-up sequence, panel LEDs
// Summary of operation
// RULE1: Power button press becomes a chipset request; it switches the supply on directly only when off.
// RULE2: When off, power button or chipset wake edge starts power-up.
// RULE3: Power-up drives power good then releases reset; system turns on.
// RULE4: Chipset off state indication drops the supply power-on request.
// RULE5: Unserviced power-off press forces power off after about 4.5 s.
// RULE6: Without OS, firmware handles button via SMI and commands chipset off.
// RULE7: With ACPI OS, the press reaches the OS via SCI.
// RULE8: Reset button press is forwarded as a chipset reset request.
// RULE9: Each identify press inverts the identify LED; a press in the same cycle as a management command is dropped.
// RULE10: Identify LED holds until next press or management command.
// RULE11: Power LED lit with DC power on, dark when off.
// RULE12: Power LED dark in S5, solid in S0, 1 Hz blink in S1.
// RULE13: Active-low buttons synchronised, debounced, one event per press.
`timescale 1ns/1ns
`default_nettype none

module fppc_core
	import fppc_pkg::*;
#(
	parameter int unsigned DEBOUNCE_COUNT  = DEBOUNCE_CYCLES,
	parameter int unsigned FORCE_OFF_COUNT = FORCE_OFF_CYCLES,
	parameter int unsigned BLINK_COUNT     = BLINK_HALF_CYCLES,
	parameter int unsigned PGOOD_COUNT     = PGOOD_CYCLES,
	parameter int unsigned RESET_COUNT     = RESET_CYCLES,
	parameter int unsigned REQ_COUNT       = REQ_CYCLES
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   srst,
	// Front panel buttons
	input  wire logic                   panel_power_button_n,
	input  wire logic                   panel_reset_button_n,
	input  wire logic                   panel_identify_button_n,
	// Management identify command
	input  wire logic                   identify_cmd_valid,
	input  wire logic                   identify_cmd_on,
	// Chipset
	input  wire logic                   chipset_wake,
	input  wire fppc_chipset_state_type chipset_state,
	output fppc_chipset_req_type        chipset_req,
	// System power
	output logic                        supply_power_on_request,
	output logic                        power_good,
	output logic                        system_reset_n,
	// Panel LEDs
	output logic                        panel_identify_led_n,
	output logic                        panel_power_led_n
);

	// ----------------------------------------------------------------
	// Button conditioning
	// ----------------------------------------------------------------
	logic [2:0] btn_raw_n;
	logic [2:0] btn_press;
	assign btn_raw_n = {panel_identify_button_n, panel_reset_button_n, panel_power_button_n};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_btn
			logic        sync_a;
			logic        sync_b;
			logic        stable;
			logic [31:0] cnt;
			always_ff @(posedge clk) begin
				if (srst) begin
					sync_a <= 1'b1;
					sync_b <= 1'b1;
					stable <= 1'b1;
					cnt    <= 32'h0;
				end else begin
					sync_a <= btn_raw_n[gi]; // RULE13
					sync_b <= sync_a;
					if (sync_b == stable) begin
						cnt <= 32'h0;
					end else if (cnt >= DEBOUNCE_COUNT - 1) begin
						cnt    <= 32'h0;
						stable <= sync_b; // RULE13
					end else begin
						cnt <= cnt + 32'h1;
					end
				end
			end
			assign btn_press[gi] = stable && !sync_b && (cnt >= DEBOUNCE_COUNT - 1); // RULE13
		end
	endgenerate

	wire power_press    = btn_press[0];
	wire reset_press    = btn_press[1];
	wire identify_press = btn_press[2];

	// ----------------------------------------------------------------
	// Chipset wake edge
	// ----------------------------------------------------------------
	logic wake_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= chipset_wake;
		end
	end
	wire wake_edge = chipset_wake != wake_q;

	// ----------------------------------------------------------------
	// Request pulses to the chipset
	// ----------------------------------------------------------------
	logic [31:0] pwr_req_cnt;
	logic [31:0] rst_req_cnt;
	always_ff @(posedge clk) begin
		if (srst) begin
			pwr_req_cnt <= 32'h0;
			rst_req_cnt <= 32'h0;
		end else begin
			if (power_press) begin
				pwr_req_cnt <= REQ_COUNT; // RULE1
			end else if (pwr_req_cnt != 32'h0) begin
				pwr_req_cnt <= pwr_req_cnt - 32'h1;
			end
			if (reset_press) begin
				rst_req_cnt <= REQ_COUNT; // RULE8
			end else if (rst_req_cnt != 32'h0) begin
				rst_req_cnt <= rst_req_cnt - 32'h1;
			end
		end
	end
	assign chipset_req = '{
		power_button: pwr_req_cnt != 32'h0, // RULE1
		reset_button: rst_req_cnt != 32'h0  // RULE8
	};

	// ----------------------------------------------------------------
	// Power sequencer
	// ----------------------------------------------------------------
	fppc_state_type state;
	fppc_state_type next_state;
	logic [31:0]    seq_cnt;
	logic           off_pending;
	logic [31:0]    off_cnt;

	wire seq_done   = seq_cnt == 32'h0;
	wire force_off  = off_pending && (off_cnt == 32'h0);
	wire go_off     = chipset_state.off_s5 || force_off;

	always_comb begin
		next_state = state;
		case (state)
			FPPC_OFF: begin
				if (power_press || wake_edge) begin
					next_state = FPPC_SUPPLY; // RULE2
				end
			end
			FPPC_SUPPLY: begin
				if (go_off) begin
					next_state = FPPC_OFF;
				end else if (seq_done) begin
					next_state = FPPC_RESET; // RULE3
				end
			end
			FPPC_RESET: begin
				if (go_off) begin
					next_state = FPPC_OFF;
				end else if (seq_done) begin
					next_state = FPPC_ON; // RULE3
				end
			end
			FPPC_ON: begin
				if (go_off) begin
					next_state = FPPC_OFF; // RULE4 RULE5
				end
			end
			default: begin
				next_state = FPPC_OFF;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state   <= FPPC_OFF;
			seq_cnt <= 32'h0;
		end else begin
			state <= next_state;
			if (next_state != state) begin
				seq_cnt <= (next_state == FPPC_SUPPLY) ? PGOOD_COUNT : RESET_COUNT;
			end else if (!seq_done) begin
				seq_cnt <= seq_cnt - 32'h1;
			end
		end
	end

	// Watchdog on an unserviced power-off press
	always_ff @(posedge clk) begin
		if (srst) begin
			off_pending <= 1'b0;
			off_cnt     <= 32'h0;
		end else if (state == FPPC_OFF || go_off) begin
			off_pending <= 1'b0;
			off_cnt     <= 32'h0;
		end else if (power_press && !off_pending) begin
			off_pending <= 1'b1; // RULE5
			off_cnt     <= FORCE_OFF_COUNT - 1;
		end else if (off_pending && off_cnt != 32'h0) begin
			off_cnt <= off_cnt - 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			supply_power_on_request <= 1'b0;
			power_good              <= 1'b0;
			system_reset_n          <= 1'b0;
		end else begin
			supply_power_on_request <= next_state != FPPC_OFF; // RULE4
			power_good              <= next_state == FPPC_RESET || next_state == FPPC_ON; // RULE3
			system_reset_n          <= next_state == FPPC_ON; // RULE3
		end
	end

	// ----------------------------------------------------------------
	// Identify LED
	// ----------------------------------------------------------------
	logic identify_on;
	always_ff @(posedge clk) begin
		if (srst) begin
			identify_on <= IDENTIFY_RESET;
		end else if (identify_cmd_valid) begin
			identify_on <= identify_cmd_on; // RULE10
		end else if (identify_press) begin
			identify_on <= !identify_on; // RULE9
		end
	end

	// ----------------------------------------------------------------
	// Power LED
	// ----------------------------------------------------------------
	logic [31:0] blink_cnt;
	logic        blink;
	always_ff @(posedge clk) begin
		if (srst) begin
			blink_cnt <= 32'h0;
			blink     <= 1'b0;
		end else if (blink_cnt >= BLINK_COUNT - 1) begin
			blink_cnt <= 32'h0;
			blink     <= !blink; // RULE12
		end else begin
			blink_cnt <= blink_cnt + 32'h1;
		end
	end

	wire dc_on   = state == FPPC_ON;
	wire led_lit = dc_on && !chipset_state.off_s5 && (!chipset_state.sleep_s1 || blink);

	always_ff @(posedge clk) begin
		if (srst) begin
			panel_identify_led_n <= 1'b1;
			panel_power_led_n    <= 1'b1;
		end else begin
			panel_identify_led_n <= !identify_on;
			panel_power_led_n    <= !led_lit; // RULE11 RULE12
		end
	end

endmodule : fppc_core

`default_nettype wire

// *** sim/fppc_monitor.sv ***
// Assertion checker for the front panel power control block
`timescale 1ns/1ns
`default_nettype none
module fppc_monitor
	import fppc_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   srst,
	input wire logic                   panel_power_button_n,
	input wire logic                   panel_reset_button_n,
	input wire logic                   panel_identify_button_n,
	input wire logic                   identify_cmd_valid,
	input wire logic                   identify_cmd_on,
	input wire logic                   chipset_wake,
	input wire fppc_chipset_state_type chipset_state,
	input wire fppc_chipset_req_type   chipset_req,
	input wire logic                   supply_power_on_request,
	input wire logic                   power_good,
	input wire logic                   system_reset_n,
	input wire logic                   panel_identify_led_n,
	input wire logic                   panel_power_led_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_supply_drop: assert property (chipset_state.off_s5 && supply_power_on_request |=>
		!supply_power_on_request && !power_good && !system_reset_n) else $error("supply held");
	a_good_first: assert property (system_reset_n |-> power_good)
		else $error("reset released early");
	a_good_supply: assert property (power_good |-> supply_power_on_request)
		else $error("good without supply");
	a_reset_delay: assert property ($rose(system_reset_n) |-> $past(power_good, 5))
		else $error("reset delay short");
	a_power_pulse: assert property ($rose(chipset_req.power_button) |->
		chipset_req.power_button[*3] ##1 !chipset_req.power_button) else $error("power req");
	a_reset_pulse: assert property ($rose(chipset_req.reset_button) |->
		chipset_req.reset_button[*3] ##1 !chipset_req.reset_button) else $error("reset req");
	a_led_dark: assert property (!supply_power_on_request && !$past(supply_power_on_request)
		|-> panel_power_led_n) else $error("power led lit while off");
	a_led_solid: assert property (system_reset_n && $past(system_reset_n) &&
		!$past(chipset_state.sleep_s1) && !$past(chipset_state.off_s5) |-> !panel_power_led_n)
		else $error("power led dark while on");
	a_id_command: assert property (identify_cmd_valid |-> ##2
		panel_identify_led_n == !$past(identify_cmd_on, 2)) else $error("identify cmd");
endmodule : fppc_monitor
`default_nettype wire

// *** sim/fppc_chipset_model.sv ***
// Chipset power-state machine model facing the block
`timescale 1ns/1ns
`default_nettype none
module fppc_chipset_model
	import fppc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire fppc_chipset_req_type   chipset_req,
	input  wire logic                   supply_power_on_request,
	input  wire logic                   system_reset_n,
	input  wire logic                   service,
	input  wire logic                   sleep,
	output fppc_chipset_state_type      chipset_state
);
	logic [3:0] wait_count;
	always_ff @(posedge clk) begin
		if (srst || !supply_power_on_request) begin
			wait_count    <= 4'h0;
			chipset_state <= '0;
		end else begin
			chipset_state.sleep_s1 <= sleep;
			if (wait_count != 4'h0)
				wait_count <= wait_count + 4'h1;
			else if (chipset_req.power_button && service && system_reset_n)
				wait_count <= 4'h1;
			if (wait_count == 4'hF)
				chipset_state.off_s5 <= 1'b1;
		end
	end
endmodule : fppc_chipset_model
`default_nettype wire

// *** sim/test_front_panel_power_control.sv ***
// Testbench for the front panel power control block
`timescale 1ns/1ns
`default_nettype none
module test_front_panel_power_control;
	import fppc_pkg::*;
	logic clk = 0, srst = 1, panel_power_button_n = 1, panel_reset_button_n = 1;
	logic panel_identify_button_n = 1, identify_cmd_valid = 0, identify_cmd_on = 0;
	logic chipset_wake = 0, service = 0, sleep = 0, prev;
	logic supply_power_on_request, power_good, system_reset_n;
	logic panel_identify_led_n, panel_power_led_n;
	fppc_chipset_state_type chipset_state;
	fppc_chipset_req_type chipset_req;
	localparam int DB = 4, FO = 50, BL = 8, PG = 10, RS = 5, RQ = 3;
	int mismatches = 0, n_checks = 0, n_pwr = 0, n_rst = 0, n, i;
	always #25 clk = ~clk;
	always @(posedge clk) begin
		n_pwr += chipset_req.power_button;
		n_rst += chipset_req.reset_button;
	end
	fppc_core #(.DEBOUNCE_COUNT(DB), .FORCE_OFF_COUNT(FO), .BLINK_COUNT(BL),
		.PGOOD_COUNT(PG), .RESET_COUNT(RS), .REQ_COUNT(RQ)) fppc_core_inst (.clk, .srst,
		.panel_power_button_n, .panel_reset_button_n, .panel_identify_button_n,
		.identify_cmd_valid, .identify_cmd_on, .chipset_wake, .chipset_state, .chipset_req,
		.supply_power_on_request, .power_good, .system_reset_n, .panel_identify_led_n,
		.panel_power_led_n);
	fppc_chipset_model fppc_chipset_model_inst (.clk, .srst, .chipset_req,
		.supply_power_on_request, .system_reset_n, .service, .sleep, .chipset_state);
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#5;
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic press(input int b, input int len);
		if (b == 0) panel_power_button_n = 0;
		if (b == 1) panel_reset_button_n = 0;
		if (b == 2) panel_identify_button_n = 0;
		cyc(len);
		{panel_power_button_n, panel_reset_button_n, panel_identify_button_n} = 3'h7;
		cyc(12);
	endtask : press
	task automatic wait_on();
		for (i = 0; i < 100 && system_reset_n !== 1'b1; i++) cyc(1);
		cyc(2);
		chk({supply_power_on_request, power_good, panel_power_led_n}, 8'h06);
	endtask : wait_on
	task automatic wait_off();
		for (i = 0; i < 100 && supply_power_on_request !== 1'b0; i++) cyc(1);
		cyc(2);
		chk({supply_power_on_request, panel_power_led_n}, 8'h01);
	endtask : wait_off
	task automatic t_identify();
		press(2, 12);
		chk(panel_identify_led_n, 8'h00);
		press(2, 12);
		chk(panel_identify_led_n, 8'h01);
		{identify_cmd_valid, identify_cmd_on} = 2'h3;
		cyc(1);
		identify_cmd_valid = 0;
		cyc(3);
		chk(panel_identify_led_n, 8'h00);
		press(2, 2);
		chk(panel_identify_led_n, 8'h00);
		{identify_cmd_valid, identify_cmd_on} = 2'h2;
		cyc(1);
		identify_cmd_valid = 0;
		cyc(3);
		chk(panel_identify_led_n, 8'h01);
	endtask : t_identify
	task automatic t_wake_and_service();
		chipset_wake = 1;
		wait_on();
		service = 1;
		press(0, 12);
		wait_off();
	endtask : t_wake_and_service
	task automatic t_forced_off();
		n_pwr = 0;
		press(0, 12);
		chk(n_pwr, 8'(RQ));
		wait_on();
		service = 0;
		press(0, 12);
		cyc(20);
		chk(supply_power_on_request, 8'h01);
		wait_off();
	endtask : t_forced_off
	task automatic t_sleep_blink();
		press(0, 12);
		wait_on();
		sleep = 1;
		cyc(4);
		n = 0;
		repeat (32) begin
			prev = panel_power_led_n;
			cyc(1);
			if (panel_power_led_n !== prev) n++;
		end
		chk(n, 8'(32 / BL));
		sleep = 0;
		cyc(3);
		chk(panel_power_led_n, 8'h00);
		n_rst = 0;
		press(1, 12);
		chk(n_rst, 8'(RQ));
	endtask : t_sleep_blink
	task automatic wrap_up();
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	initial begin
		cyc(6);
		srst = 0;
		cyc(2);
		t_identify();
		t_wake_and_service();
		t_forced_off();
		t_sleep_blink();
		wrap_up();
	end
	initial begin
		#250000;
		mismatches++;
		wrap_up();
	end
endmodule : test_front_panel_power_control
bind fppc_core fppc_monitor fppc_monitor_inst (.clk, .srst, .panel_power_button_n,
	.panel_reset_button_n, .panel_identify_button_n, .identify_cmd_valid, .identify_cmd_on,
	.chipset_wake, .chipset_state, .chipset_req, .supply_power_on_request, .power_good,
	.system_reset_n, .panel_identify_led_n, .panel_power_led_n);
`default_nettype wire
